// File: dmag_core.v
`timescale 1ns/1ps
`include "dmag_defines.vh"

// Operation
// R1 - post and pre steps carry across pointer bytes
// R2 - pointer steps never touch arithmetic flags
// R3 - indirect read of virtual target returns zero
// R4 - indirect write to virtual target does nothing
// R5 - virtual write into pointer stores without step
// R6 - pointer bytes are directly readable and writable
// R7 - indirect reaches other special registers normally
// R8 - extended addressing only when enable bit set
// R9 - pointers zero and one unchanged in extended
// R10 - indexed mode: enabled, select clear, operand <=5Fh
// R11 - indexed target is pointer two plus operand
// R12 - select clear, operand >=60h hits F60h-FFFh
// R13 - select set uses bank select register
// R14 - inherent and literal instructions not affected
// R15 - remap only hits indexed, banked still reaches bank0
// R16 - pointer is 12 bits, high nibble unused
// R17 - post-dec, post-inc, pre-inc access order
// R18 - accumulator offset adds signed value, no change
// R19 - core direct: bank select or access bank
// R20 - indexed sum truncated to 12 bits
module dmag_core
(
  // clock and reset
  input  wire        i_clk,
  input  wire        i_reset_n,
  // configuration
  input  wire        i_extended_set_enable,
  // decoder request
  input  wire        i_req,
  input  wire        i_select,
  input  wire [7:0]  i_operand,
  input  wire        i_full_addr_en,
  input  wire [11:0] i_full_addr,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [7:0]  i_wdata,
  input  wire [7:0]  i_accumulator,
  // data memory side
  input  wire [7:0]  i_mem_rdata,
  output wire [11:0] o_mem_addr,
  output wire        o_mem_rd,
  output wire        o_mem_wr,
  output wire [7:0]  o_mem_wdata,
  // answer to the decoder
  output reg  [7:0]  o_rdata,
  output reg         o_rvalid,
  output wire [3:0]  o_bank_select_register,
  output wire [11:0] o_pointer_pair_zero,
  output wire [11:0] o_pointer_pair_one,
  output wire [11:0] o_pointer_pair_two
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [3:0]  bsr_q;          // bank select register
  wire [11:0] ptr [0:2];      // pointer values
  reg  [11:0] direct_addr;    // address named by the instruction
  wire        dir_virt;       // direct address is a virtual operand
  wire [1:0]  dir_sel;        // which pointer it belongs to
  wire [2:0]  dir_op;         // which operand
  reg  [11:0] base_ptr;       // selected pointer value
  reg  [11:0] eff_addr;       // final data address
  wire        tgt_virt;       // final address is itself virtual
  reg         tgt_is_ptr;     // final address is a pointer byte or bank select
  reg  [2:0]  inc_v;          // step up per pointer
  reg  [2:0]  dec_v;          // step down per pointer
  reg  [2:0]  wr_lo;          // low byte write per pointer
  reg  [2:0]  wr_hi;          // high byte write per pointer
  reg         wr_bsr;         // bank select write
  reg  [7:0]  reg_rdata;      // read data of a local register
  reg         reg_hit;        // final address is local
  reg  [7:0]  rdata_d;        // next read data
  wire        do_wr;          // accepted write
  wire        do_rd;          // accepted read

  //////////////////////////////////////////////////////////////////////////////
  // direct address formation

  // indexed, access bank or banked address from select bit and operand
  always @*
  begin
    if (i_full_addr_en)
    begin
      direct_addr = i_full_addr;  // full address ignores banking
    end
    else if (i_select)
    begin
      direct_addr = {bsr_q, i_operand};  // R13 R15 R19
    end
    else if (i_extended_set_enable && i_operand < `DMAG_ACCESS_SPLIT)  // R8 R10
    begin
      direct_addr = ptr[2] + {4'h0, i_operand};  // R11 R20
    end
    else if (i_operand < `DMAG_ACCESS_SPLIT)
    begin
      direct_addr = {4'h0, i_operand};  // R19
    end
    else
    begin
      direct_addr = {`DMAG_SFR_BASE, i_operand};  // R12
    end
  end

  // find out whether the instruction named a virtual operand
  dmag_operand_decode u_dir_dec
  (
    .i_addr    (direct_addr),
    .o_virt    (dir_virt),
    .o_ptr_sel (dir_sel),
    .o_op      (dir_op)
  );

  //////////////////////////////////////////////////////////////////////////////
  // indirect address formation

  // pick pointer, then apply pre-step or signed accumulator offset
  always @*
  begin
    case (dir_sel)
      2'h0:    base_ptr = ptr[0];
      2'h1:    base_ptr = ptr[1];
      2'h2:    base_ptr = ptr[2];
      default: base_ptr = ptr[0];
    endcase
    eff_addr = direct_addr;
    if (dir_virt)
    begin
      case (dir_op)
        `DMAG_VOP_BEFORE_INCREMENT_OPERAND:  eff_addr = base_ptr + 12'h001;  // R17
        `DMAG_VOP_PLUSACC: eff_addr = base_ptr + {{4{i_accumulator[7]}}, i_accumulator};  // R18
        default:           eff_addr = base_ptr;  // R17
      endcase
    end
  end

  // the pointed location might be a virtual operand as well
  dmag_operand_decode u_tgt_dec
  (
    .i_addr    (eff_addr),
    .o_virt    (tgt_virt),
    .o_ptr_sel (),  // a virtual target is refused whatever pointer owns it
    .o_op      ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // local register decode

  // pointer bytes and bank select live here; everything else except a virtual target is memory
  always @*
  begin
    reg_hit   = 1'b1;
    reg_rdata = 8'h00;
    case (eff_addr)
      `DMAG_ADDR_PTR0_LOW:  reg_rdata = ptr[0][7:0];  // R6
      `DMAG_ADDR_PTR0_HIGH: reg_rdata = {4'h0, ptr[0][11:8]};  // R16
      `DMAG_ADDR_PTR1_LOW:  reg_rdata = ptr[1][7:0];
      `DMAG_ADDR_PTR1_HIGH: reg_rdata = {4'h0, ptr[1][11:8]};
      `DMAG_ADDR_PTR2_LOW:  reg_rdata = ptr[2][7:0];
      `DMAG_ADDR_PTR2_HIGH: reg_rdata = {4'h0, ptr[2][11:8]};
      `DMAG_ADDR_BSR:       reg_rdata = {4'h0, bsr_q};
      default:              reg_hit   = 1'b0;
    endcase
    tgt_is_ptr = reg_hit;
  end

  // a virtual target blocks the write; the read is still accepted
  assign do_wr = i_req && i_write && !tgt_virt;  // R4
  assign do_rd = i_req && i_read;

  //////////////////////////////////////////////////////////////////////////////
  // pointer updates

  // byte writes and operand steps; a write into the pointer cancels the step
  always @*
  begin
    inc_v  = 3'b000;
    dec_v  = 3'b000;
    wr_lo  = 3'b000;
    wr_hi  = 3'b000;
    wr_bsr = 1'b0;
    if (do_wr)
    begin
      case (eff_addr)
        `DMAG_ADDR_PTR0_LOW:  wr_lo[0] = 1'b1;  // R6
        `DMAG_ADDR_PTR0_HIGH: wr_hi[0] = 1'b1;
        `DMAG_ADDR_PTR1_LOW:  wr_lo[1] = 1'b1;
        `DMAG_ADDR_PTR1_HIGH: wr_hi[1] = 1'b1;
        `DMAG_ADDR_PTR2_LOW:  wr_lo[2] = 1'b1;
        `DMAG_ADDR_PTR2_HIGH: wr_hi[2] = 1'b1;
        `DMAG_ADDR_BSR:       wr_bsr   = 1'b1;
        default:              wr_bsr   = 1'b0;
      endcase
    end
    // a step happens on any request, even a blocked one, since the operand was used
    if (i_req && dir_virt)
    begin
      case (dir_op)
        `DMAG_VOP_BEFORE_INCREMENT_OPERAND:  inc_v[dir_sel] = 1'b1;  // R1 R17
        `DMAG_VOP_AFTER_INCREMENT_OPERAND: inc_v[dir_sel] = 1'b1;  // R1 R17
        `DMAG_VOP_AFTER_DECREMENT_OPERAND: dec_v[dir_sel] = 1'b1;  // R1 R17
        default:           inc_v = 3'b000;
      endcase
    end
  end

  // three identical pointer pairs; write priority in the pair drops the step
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_ptr
      dmag_pointer u_ptr
      (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_wr_low  (wr_lo[gi]),  // R5
        .i_wr_high (wr_hi[gi]),
        .i_wdata   (i_wdata),
        .i_inc     (inc_v[gi]),
        .i_dec     (dec_v[gi]),
        .o_ptr     (ptr[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // bank select register

  // only the low nibble exists
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      bsr_q <= `DMAG_RST_BSR;
    end
    else if (wr_bsr)
    begin
      bsr_q <= i_wdata[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memory port and read return

  // other special registers go straight to memory with normal effects
  assign o_mem_addr  = eff_addr;  // R7 R9
  assign o_mem_rd    = do_rd && !tgt_virt && !tgt_is_ptr;
  assign o_mem_wr    = do_wr && !tgt_is_ptr;
  assign o_mem_wdata = i_wdata;

  // memory answers in the same cycle; result is registered
  always @*
  begin
    if (tgt_virt)
    begin
      rdata_d = `DMAG_VIRT_READ;  // R3
    end
    else if (tgt_is_ptr)
    begin
      rdata_d = reg_rdata;  // R6
    end
    else
    begin
      rdata_d = i_mem_rdata;
    end
  end

  // read data holds until the next read
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rdata  <= `DMAG_RST_RDATA;
      o_rvalid <= `DMAG_RST_RVALID;
    end
    else
    begin
      o_rvalid <= do_rd;
      if (do_rd)
      begin
        o_rdata <= rdata_d;
      end
    end
  end

  // inherent and literal instructions never raise i_req, so are untouched
  assign o_bank_select_register = bsr_q;  // R14
  assign o_pointer_pair_zero    = ptr[0];
  assign o_pointer_pair_one     = ptr[1];
  assign o_pointer_pair_two     = ptr[2];

endmodule

// File: dmag_defines.vh
`ifndef DMAG_DEFINES_VH
`define DMAG_DEFINES_VH

// special-function addresses of the pointer pairs and bank select
`define DMAG_ADDR_PTR2_LOW     12'hfd9
`define DMAG_ADDR_PTR2_HIGH    12'hfda
`define DMAG_ADDR_BSR          12'hfe0
`define DMAG_ADDR_PTR1_LOW     12'hfe1
`define DMAG_ADDR_PTR1_HIGH    12'hfe2
`define DMAG_ADDR_PTR0_LOW     12'hfe9
`define DMAG_ADDR_PTR0_HIGH    12'hfea
// virtual operand block of each pointer: base is the accumulator-offset operand
`define DMAG_ADDR_VIRT2_BASE   12'hfdb
`define DMAG_ADDR_VIRT1_BASE   12'hfe3
`define DMAG_ADDR_VIRT0_BASE   12'hfeb
// offsets inside a virtual block
`define DMAG_VOP_PLUSACC       3'h0
`define DMAG_VOP_BEFORE_INCREMENT_OPERAND        3'h1
`define DMAG_VOP_AFTER_DECREMENT_OPERAND       3'h2
`define DMAG_VOP_AFTER_INCREMENT_OPERAND       3'h3
`define DMAG_VOP_PLAIN         3'h4
// indirect operand one sits at this address
`define DMAG_ADDR_IND1         12'hfe7
// access-bank split point and upper special area base
`define DMAG_ACCESS_SPLIT      8'h60
`define DMAG_SFR_BASE          4'hf
// read data returned for a virtual target
`define DMAG_VIRT_READ         8'h00
// reset values
`define DMAG_RST_PTR           12'h000
`define DMAG_RST_BSR           4'h0
`define DMAG_RST_RDATA         8'h00
`define DMAG_RST_RVALID        1'b0

`endif

// File: dmag_pointer.v
`timescale 1ns/1ps
`include "dmag_defines.vh"

// one 12-bit pointer pair with its byte writes and step updates
module dmag_pointer
(
  // clock and reset
  input  wire        i_clk,
  input  wire        i_reset_n,
  // byte writes
  input  wire        i_wr_low,
  input  wire        i_wr_high,
  input  wire [7:0]  i_wdata,
  // step requests
  input  wire        i_inc,
  input  wire        i_dec,
  // pointer value
  output wire [11:0] o_ptr
);

  reg  [11:0] ptr_q;  // pointer pair
  reg  [11:0] ptr_d;  // next pointer

  // byte write beats a step, a step runs over the full 12 bits so carry crosses bytes
  always @*
  begin
    ptr_d = ptr_q;
    if (i_wr_low)
    begin
      ptr_d[7:0] = i_wdata;
    end
    else if (i_wr_high)
    begin
      ptr_d[11:8] = i_wdata[3:0];  // R16
    end
    else if (i_inc)
    begin
      ptr_d = ptr_q + 12'h001;  // R1
    end
    else if (i_dec)
    begin
      ptr_d = ptr_q - 12'h001;  // R1
    end
  end

  // register; no flag is produced here at all
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ptr_q <= `DMAG_RST_PTR;
    end
    else
    begin
      ptr_q <= ptr_d;  // R2
    end
  end

  assign o_ptr = ptr_q;

endmodule

// File: dmag_operand_decode.v
`timescale 1ns/1ps
`include "dmag_defines.vh"

// classifies a 12-bit address as one of the virtual operands
module dmag_operand_decode
(
  // address in
  input  wire [11:0] i_addr,
  // classification
  output reg         o_virt,
  output reg  [1:0]  o_ptr_sel,
  output reg  [2:0]  o_op
);

  reg [11:0] rel;  // offset into a virtual block

  // three blocks of five operands each
  always @*
  begin
    rel       = 12'h000;
    o_virt    = 1'b0;
    o_ptr_sel = 2'h0;
    o_op      = 3'h0;
    if (i_addr >= `DMAG_ADDR_VIRT0_BASE && i_addr <= `DMAG_ADDR_VIRT0_BASE + 12'h004)
    begin
      rel    = i_addr - `DMAG_ADDR_VIRT0_BASE;
      o_virt = 1'b1;
      o_ptr_sel = 2'h0;
    end
    else if (i_addr >= `DMAG_ADDR_VIRT1_BASE && i_addr <= `DMAG_ADDR_VIRT1_BASE + 12'h004)
    begin
      rel    = i_addr - `DMAG_ADDR_VIRT1_BASE;
      o_virt = 1'b1;
      o_ptr_sel = 2'h1;
    end
    else if (i_addr >= `DMAG_ADDR_VIRT2_BASE && i_addr <= `DMAG_ADDR_VIRT2_BASE + 12'h004)
    begin
      rel    = i_addr - `DMAG_ADDR_VIRT2_BASE;
      o_virt = 1'b1;
      o_ptr_sel = 2'h2;
    end
    o_op = rel[2:0];
  end

endmodule

// File: dmag_core_properties.sv
`timescale 1ns/1ps
// checker for the address generator, sees only the top ports
module dmag_core_properties
(
  // clock and reset
  input wire        i_clk,
  input wire        i_reset_n,
  // request side
  input wire        i_extended_set_enable,
  input wire        i_req,
  input wire        i_select,
  input wire [7:0]  i_operand,
  input wire        i_full_addr_en,
  input wire [11:0] i_full_addr,
  input wire        i_read,
  input wire        i_write,
  input wire [7:0]  i_accumulator,
  // answer side
  input wire [11:0] o_mem_addr,
  input wire        o_mem_rd,
  input wire        o_mem_wr,
  input wire        o_rvalid,
  input wire [3:0]  o_bank_select_register,
  input wire [11:0] o_pointer_pair_zero,
  input wire [11:0] o_pointer_pair_two
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////
  // direct request that really reaches memory
  wire dir_strobe = i_req && !i_full_addr_en && (o_mem_rd || o_mem_wr);
  // an address inside one of the three virtual operand blocks
  function automatic logic virt_at(input logic [11:0] a);
    virt_at = (a >= 12'hfdb && a <= 12'hfdf) || (a >= 12'hfe3 && a <= 12'hfe7) ||
              (a >= 12'hfeb && a <= 12'hfef);
  endfunction
  // virtual operand blocks must never be stored to
  wire virt_addr  = virt_at(o_mem_addr);
  ////////////////////////////////////////////////////////////////////
  property p_rvalid;
    i_req && i_read |=> o_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_quiet;
    !i_req |-> !o_mem_rd && !o_mem_wr;
  endproperty
  a_quiet: assert property (p_quiet) else $error("strobe without request");
  property p_bank;
    // a direct name of a virtual operand turns into an indirect access
    dir_strobe && i_select && !virt_at({o_bank_select_register, i_operand})
      |-> o_mem_addr == {o_bank_select_register, i_operand};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_index;
    dir_strobe && !i_select && i_extended_set_enable && i_operand <= 8'h5f
      && !virt_at(o_pointer_pair_two + {4'h0, i_operand})
      |-> o_mem_addr == o_pointer_pair_two + {4'h0, i_operand};
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");
  property p_upper;
    dir_strobe && !i_select && i_operand >= 8'h60 && !virt_at({4'hf, i_operand})
      |-> o_mem_addr == {4'hf, i_operand};
  endproperty
  a_upper: assert property (p_upper) else $error("upper access address wrong");
  property p_core;
    dir_strobe && !i_select && !i_extended_set_enable && i_operand <= 8'h5f
      |-> o_mem_addr == {4'h0, i_operand};
  endproperty
  a_core: assert property (p_core) else $error("access bank address wrong");
  property p_novirt;
    o_mem_wr |-> !virt_addr;
  endproperty
  a_novirt: assert property (p_novirt) else $error("store to virtual operand");
  property p_step;
    i_req && i_full_addr_en && i_full_addr == 12'hfee && !i_write
      |=> o_pointer_pair_zero == $past(o_pointer_pair_zero) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("after-increment step wrong");
  property p_accumulator_offset_operand;
    i_req && i_full_addr_en && i_full_addr == 12'hfeb && !i_write && o_mem_rd
      |-> (o_mem_addr == o_pointer_pair_zero + {{4{i_accumulator[7]}}, i_accumulator})
      ##1 $stable(o_pointer_pair_zero);
  endproperty
  a_accumulator_offset_operand: assert property (p_accumulator_offset_operand) else $error("accumulator offset wrong");
endmodule

// File: dmag_data_memory.sv
`timescale 1ns/1ps
// data memory beyond the block: combinational read, clocked store
module dmag_data_memory
(
  // clock
  input  wire        i_clk,
  // access
  input  wire [11:0] i_addr,
  input  wire        i_rd,
  input  wire        i_wr,
  input  wire [7:0]  i_wdata,
  output wire [7:0]  o_rdata
);
  reg [7:0] mem_q [0:4095]; // storage
  reg [7:0] last_q = 8'h00; // last value shown on the read lines
  // store on the edge that takes the write
  always @(posedge i_clk)
  begin
    if (i_wr)
      mem_q[i_addr] <= i_wdata;
    if (i_rd)
      last_q <= mem_q[i_addr];
  end
  // lines not held by a read show the inverted last value, not the last value
  assign o_rdata = i_rd ? mem_q[i_addr] : ~last_q;
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         clk = 1'b0, rst_n = 1'b0, ext = 1'b0, req = 1'b0, sel = 1'b0;
  reg         fae = 1'b0, rd = 1'b0, wr = 1'b0;
  reg  [7:0]  op = 8'h00, wd = 8'h00, accu = 8'h00;
  reg  [11:0] fa = 12'h000, addr_seen;
  wire [11:0] maddr, p0, p1, p2;
  wire [7:0]  mwd, mrd_data, rdata;
  wire        mrd, mwr, rvalid;
  wire [3:0]  bank_select_register;
  integer     bad_count = 0, checks_done = 0;
  dmag_core dmag_core_i (.i_clk(clk), .i_reset_n(rst_n), .i_extended_set_enable(ext),
    .i_req(req), .i_select(sel), .i_operand(op), .i_full_addr_en(fae), .i_full_addr(fa),
    .i_read(rd), .i_write(wr), .i_wdata(wd), .i_accumulator(accu), .i_mem_rdata(mrd_data),
    .o_mem_addr(maddr), .o_mem_rd(mrd), .o_mem_wr(mwr), .o_mem_wdata(mwd), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_bank_select_register(bank_select_register), .o_pointer_pair_zero(p0),
    .o_pointer_pair_one(p1), .o_pointer_pair_two(p2));
  dmag_data_memory dmag_data_memory_i (.i_clk(clk), .i_addr(maddr), .i_rd(mrd), .i_wr(mwr),
    .i_wdata(mwd), .o_rdata(mrd_data));
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task check(input [11:0] seen, input [11:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  // one access held over one rising edge; request stays up afterwards
  task go(input f, input [11:0] a, input s, input r, input w, input [7:0] d);
  begin
    req = 1'b1; fae = f; fa = a; op = a[7:0]; sel = s; rd = r; wr = w; wd = d;
    #5 addr_seen = maddr;
    @(posedge clk);
    @(negedge clk);
  end
  endtask
  // pointer pair written byte by byte through its direct addresses
  task setp(input [11:0] lo, input [11:0] v);
  begin
    go(1'b1, lo, 1'b0, 1'b0, 1'b1, v[7:0]);
    go(1'b1, lo + 12'h001, 1'b0, 1'b0, 1'b1, {4'h0, v[11:8]});
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_direct;
  begin
    setp(12'hfe9, 12'haff);
    check(p0, 12'haff);
    go(1'b1, 12'hfea, 1'b0, 1'b0, 1'b1, 8'hfa);
    go(1'b1, 12'hfea, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h00a);
    go(1'b1, 12'hfe0, 1'b0, 1'b0, 1'b1, 8'h05);
    go(1'b0, 12'h010, 1'b1, 1'b0, 1'b1, 8'h5a);
    check(addr_seen, 12'h510);
    go(1'b1, 12'h510, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h05a);
    $display("test direct done");
  end
  endtask
  task t_step;
  begin
    go(1'b1, 12'haff, 1'b0, 1'b0, 1'b1, 8'h11);
    go(1'b1, 12'hb00, 1'b0, 1'b0, 1'b1, 8'h22);
    go(1'b1, 12'hfee, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h011);
    check(p0, 12'hb00);
    check({11'h000, rvalid}, 12'h001);
    go(1'b1, 12'hfed, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h022);
    check(p0, 12'haff);
    go(1'b1, 12'hfec, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h022);
    accu = 8'hff;
    go(1'b1, 12'hfeb, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h011);
    check(p0, 12'hb00);
    $display("test steps done");
  end
  endtask
  task t_virtual;
  begin
    setp(12'hfe1, 12'h300);
    go(1'b1, 12'h300, 1'b0, 1'b0, 1'b1, 8'h33);
    setp(12'hfe9, 12'hfe7);
    go(1'b1, 12'hfef, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h000);
    go(1'b1, 12'hfef, 1'b0, 1'b0, 1'b1, 8'h99);
    go(1'b1, 12'h300, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h033);
    check(p1, 12'h300);
    setp(12'hfd9, 12'hfd9);
    go(1'b1, 12'hfdd, 1'b0, 1'b0, 1'b1, 8'h44);
    check(p2, 12'hf44);
    setp(12'hfd9, 12'hfd9);
    go(1'b1, 12'hfdf, 1'b0, 1'b0, 1'b1, 8'h66);
    check(p2, 12'hf66);
    setp(12'hfe9, 12'hfe0);
    go(1'b1, 12'hfef, 1'b0, 1'b0, 1'b1, 8'h07);
    check({8'h00, bank_select_register}, 12'h007);
    $display("test virtual done");
  end
  endtask
  task t_ext;
  begin
    ext = 1'b1;
    setp(12'hfd9, 12'h120);
    go(1'b0, 12'h005, 1'b0, 1'b0, 1'b1, 8'h77);
    check(addr_seen, 12'h125);
    go(1'b1, 12'h125, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h077);
    go(1'b1, 12'hfe7, 1'b0, 1'b1, 1'b0, 8'h00);
    check({4'h0, rdata}, 12'h033);
    go(1'b0, 12'h05f, 1'b0, 1'b1, 1'b0, 8'h00);
    check(addr_seen, 12'h17f);
    go(1'b0, 12'h060, 1'b0, 1'b1, 1'b0, 8'h00);
    check(addr_seen, 12'hf60);
    go(1'b1, 12'hfe0, 1'b0, 1'b0, 1'b1, 8'h00);
    go(1'b0, 12'h005, 1'b1, 1'b1, 1'b0, 8'h00);
    check(addr_seen, 12'h005);
    setp(12'hfd9, 12'hfff);
    go(1'b0, 12'h002, 1'b0, 1'b1, 1'b0, 8'h00);
    check(addr_seen, 12'h001);
    ext = 1'b0;
    go(1'b0, 12'h005, 1'b0, 1'b1, 1'b0, 8'h00);
    check(addr_seen, 12'h005);
    $display("test extended done");
  end
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence: reset for four cycles, then each test in turn
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_direct;
    t_step;
    t_virtual;
    t_ext;
    report_and_stop;
  end
  // watchdog: tests need about fifty cycles
  initial
  begin
    #(2000 * 20);
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule
bind dmag_core dmag_core_properties dmag_core_properties_i (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_extended_set_enable(i_extended_set_enable), .i_req(i_req),
  .i_select(i_select), .i_operand(i_operand), .i_full_addr_en(i_full_addr_en),
  .i_full_addr(i_full_addr), .i_read(i_read), .i_write(i_write),
  .i_accumulator(i_accumulator), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
  .o_mem_wr(o_mem_wr), .o_rvalid(o_rvalid), .o_bank_select_register(o_bank_select_register),
  .o_pointer_pair_zero(o_pointer_pair_zero), .o_pointer_pair_two(o_pointer_pair_two));
